// ==== design/sepc_defines.vh ====
// Constants for the serial EEPROM command port
`ifndef SEPC_DEFINES_VH
`define SEPC_DEFINES_VH

// ------------------------------------------------------------
// Opcodes and extended sub-commands
// ------------------------------------------------------------
`define SEPC_OP_EXT 2'b00
`define SEPC_OP_WRITE 2'b01
`define SEPC_OP_READ 2'b10
`define SEPC_OP_ERASE 2'b11
`define SEPC_EXT_WRITE_DISABLE_CMD 2'b00
`define SEPC_EXT_WRITE_ALL_CMD 2'b01
`define SEPC_EXT_ERASE_ALL_CMD 2'b10
`define SEPC_EXT_WEN 2'b11

// ------------------------------------------------------------
// Bit counts after the start bit (opcode + address, + data) and data widths
// ------------------------------------------------------------
`define SEPC_ADDR_END_BYTE 5'h0b
`define SEPC_ADDR_END_WORD 5'h0a
`define SEPC_DATA_END_BYTE 5'h13
`define SEPC_DATA_END_WORD 5'h1a
`define SEPC_DW_BYTE 5'h08
`define SEPC_DW_WORD 5'h10

// ------------------------------------------------------------
// Array and timing
// ------------------------------------------------------------
`define SEPC_WORDS 18'h00100
`define SEPC_ERASED 16'hffff
`define SEPC_CLK_PERIOD_NS 25
`define SEPC_TWP_NS 5000000
`define SEPC_PROG_CYCLES (`SEPC_TWP_NS / `SEPC_CLK_PERIOD_NS)

`endif

// ==== design/sepc_sync.v ====
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module sepc_sync #(
   parameter WIDTH = 5
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Data
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);

   // ------------------------------------------------------------
   // Per-bit synchroniser stages
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         reg meta_r;
         reg sync_r;
         // First flop feeds only the second
         always @(posedge clk) begin
            if (reset) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end else begin
               meta_r <= d[gi];
               sync_r <= meta_r;
            end
         end
         assign q[gi] = sync_r;
      end
   endgenerate

endmodule

// ==== design/sepc_mem.v ====
// Storage array: 256 words of two byte lanes, registered read data
`timescale 1ns/1ps
module sepc_mem (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Write port
   input wire wr_en,
   input wire [1:0] wr_be,
   input wire [7:0] wr_addr,
   input wire [15:0] wr_data,
   // Read port
   input wire [7:0] rd_addr,
   output wire [15:0] rd_data
);

   // ------------------------------------------------------------
   // One array per byte lane
   // ------------------------------------------------------------
   genvar gl;
   generate
      for (gl = 0; gl < 2; gl = gl + 1) begin : g_lane
         reg [7:0] cell_r [0:255];
         reg [7:0] rd_r;
         // Lane write and registered read
         always @(posedge clk) begin
            if (wr_en && wr_be[gl]) begin
               cell_r[wr_addr] <= wr_data[gl*8 +: 8];
            end
            if (reset) begin
               rd_r <= 8'h00;
            end else begin
               rd_r <= cell_r[rd_addr];
            end
         end
         assign rd_data[gl*8 +: 8] = rd_r;
      end
   endgenerate

endmodule

// ==== design/sepc_core.v ====
// Serial EEPROM command port: instruction decoder, read streamer, program timer
`timescale 1ns/1ps
`include "sepc_defines.vh"
module sepc_core #(
   parameter PROG_CYCLES = `SEPC_PROG_CYCLES
) (
   // System
   input wire SYS_CLK,
   input wire RESET,
   // Supply monitor, high while supply is below threshold
   input wire POR_ACTIVE,
   // Serial link pins
   input wire CHIP_SELECT,
   input wire SERIAL_CLOCK_IN,
   input wire DATA_IN,
   input wire ORGANIZATION_SELECT,
   // Serial data output pin
   output wire DATA_OUT,
   output wire DATA_OUT_OE,
   // Status
   output wire PROG_BUSY,
   output wire WRITE_ENABLED
);

   // ------------------------------------------------------------
   // States and constants
   // ------------------------------------------------------------
   localparam [2:0] ST_RESET = 3'h0;
   localparam [2:0] ST_STANDBY = 3'h1;
   localparam [2:0] ST_CMD = 3'h2;
   localparam [2:0] ST_READ = 3'h3;
   localparam [2:0] ST_DONE = 3'h4;
   localparam [2:0] ST_PROG = 3'h5;
   localparam [2:0] ST_IGNORE = 3'h6;
   localparam [17:0] PROG_LAST = PROG_CYCLES[17:0] - 18'h00001;

   // ------------------------------------------------------------
   // Decoding functions
   // ------------------------------------------------------------
   // Bits after start bit until the address is complete
   function [4:0] addr_end;
      input word_mode;
      begin
         addr_end = word_mode ? `SEPC_ADDR_END_WORD : `SEPC_ADDR_END_BYTE;
      end
   endfunction

   // Bits after start bit until the data is complete
   function [4:0] data_end;
      input word_mode;
      begin
         data_end = word_mode ? `SEPC_DATA_END_WORD : `SEPC_DATA_END_BYTE;
      end
   endfunction

   // Data word width
   function [4:0] data_width;
      input word_mode;
      begin
         data_width = word_mode ? `SEPC_DW_WORD : `SEPC_DW_BYTE;
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ------------------------------------------------------------
   wire [4:0] pins_s;
   wire cs_s;
   wire serial_clock_in_s;
   wire din_s;
   wire organization_select_s;
   wire por_s;
   reg serial_clock_in_d_r;
   reg cs_d_r;

   sepc_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk(SYS_CLK),
      .reset(RESET),
      .d({POR_ACTIVE, ORGANIZATION_SELECT, DATA_IN, SERIAL_CLOCK_IN, CHIP_SELECT}),
      .q(pins_s)
   );

   assign cs_s = pins_s[0];
   assign serial_clock_in_s = pins_s[1];
   assign din_s = pins_s[2];
   assign organization_select_s = pins_s[3];
   assign por_s = pins_s[4];

   // Delayed copies for edge detection
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         serial_clock_in_d_r <= 1'b0;
         cs_d_r <= 1'b0;
      end else begin
         serial_clock_in_d_r <= serial_clock_in_s;
         cs_d_r <= cs_s;
      end
   end

   wire serial_clock_in_rise = serial_clock_in_s & ~serial_clock_in_d_r & cs_s;
   wire cs_rise = cs_s & ~cs_d_r;

   // ------------------------------------------------------------
   // Controller registers
   // ------------------------------------------------------------
   reg [2:0] st_r;
   reg word_r;
   reg wen_r;
   reg [4:0] cnt_r;
   reg [25:0] sreg_r;
   reg [1:0] op_r;
   reg [8:0] addr_r;
   reg [15:0] data_r;
   reg pend_r;
   reg all_r;
   reg [17:0] prog_cnt_r;
   reg stat_r;
   reg [8:0] ptr_r;
   reg [15:0] sh_r;
   reg [4:0] rem_r;
   reg rd_bit_r;
   reg dout_r;
   reg oe_r;

   // Shift and count values after the current serial bit
   wire [25:0] sreg_nxt = {sreg_r[24:0], din_s};
   wire [4:0] cnt_nxt = cnt_r + 5'h01;
   wire [1:0] op_nxt = word_r ? sreg_nxt[9:8] : sreg_nxt[10:9];
   wire [8:0] addr_nxt = word_r ? {1'b0, sreg_nxt[7:0]} : sreg_nxt[8:0];
   wire [1:0] ext_nxt = word_r ? sreg_nxt[7:6] : sreg_nxt[8:7];
   wire [15:0] data_nxt = word_r ? sreg_nxt[15:0] : {sreg_nxt[7:0], sreg_nxt[7:0]};

   // ------------------------------------------------------------
   // Memory access
   // ------------------------------------------------------------
   wire [15:0] rd_data;
   wire [7:0] rd_addr = word_r ? ptr_r[7:0] : ptr_r[8:1];
   wire prog_in_all = prog_cnt_r < `SEPC_WORDS;
   wire wr_en = (st_r == ST_PROG) && (all_r ? prog_in_all : (prog_cnt_r == 18'h00000));
   wire [7:0] wr_addr = all_r ? prog_cnt_r[7:0] : (word_r ? addr_r[7:0] : addr_r[8:1]);
   wire [1:0] wr_be = (all_r || word_r) ? 2'b11 : (addr_r[0] ? 2'b10 : 2'b01);
   wire [15:0] rd_sel = word_r ? rd_data :
                        {(ptr_r[0] ? rd_data[15:8] : rd_data[7:0]), 8'h00};
   wire [8:0] ptr_inc = word_r ? {1'b0, ptr_r[7:0] + 8'h01} : ptr_r + 9'h001;

   sepc_mem u_mem (
      .clk(SYS_CLK),
      .reset(RESET),
      .wr_en(wr_en),
      .wr_be(wr_be),
      .wr_addr(wr_addr),
      .wr_data(data_r),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // ------------------------------------------------------------
   // Instruction state machine
   // ------------------------------------------------------------
   always @(posedge SYS_CLK) begin
      if (RESET || por_s) begin
         // Power-on or brown-out drops everything, latch cleared
         st_r <= ST_RESET;
         word_r <= 1'b0;
         wen_r <= 1'b0;
         cnt_r <= 5'h00;
         sreg_r <= 26'h0000000;
         op_r <= 2'b00;
         addr_r <= 9'h000;
         data_r <= 16'h0000;
         pend_r <= 1'b0;
         all_r <= 1'b0;
         prog_cnt_r <= 18'h00000;
         stat_r <= 1'b0;
         ptr_r <= 9'h000;
         sh_r <= 16'h0000;
         rem_r <= 5'h00;
         rd_bit_r <= 1'b0;
      end else begin
         // Status window opens when chip select rises during programming
         if (st_r == ST_PROG && cs_rise) begin
            stat_r <= 1'b1;
         end else if (!cs_s) begin
            stat_r <= 1'b0;
         end
         case (st_r)
            ST_RESET: begin
               st_r <= ST_STANDBY;
            end
            ST_STANDBY: begin
               // Leading zeros are skipped until the start bit
               if (serial_clock_in_rise && din_s) begin
                  st_r <= ST_CMD;
                  word_r <= organization_select_s;
                  cnt_r <= 5'h00;
                  sreg_r <= 26'h0000000;
                  pend_r <= 1'b0;
                  all_r <= 1'b0;
                  stat_r <= 1'b0;
               end
            end
            ST_CMD: begin
               if (!cs_s) begin
                  st_r <= ST_STANDBY;
               end else if (serial_clock_in_rise) begin
                  sreg_r <= sreg_nxt;
                  cnt_r <= cnt_nxt;
                  if (cnt_nxt == addr_end(word_r)) begin
                     op_r <= op_nxt;
                     addr_r <= addr_nxt;
                     case (op_nxt)
                        `SEPC_OP_READ: begin
                           st_r <= ST_READ;
                           ptr_r <= addr_nxt;
                           rd_bit_r <= 1'b0;
                           rem_r <= 5'h00;
                        end
                        `SEPC_OP_ERASE: begin
                           st_r <= ST_DONE;
                           pend_r <= wen_r;
                           data_r <= `SEPC_ERASED;
                        end
                        `SEPC_OP_WRITE: begin
                           st_r <= ST_CMD;
                        end
                        default: begin
                           case (ext_nxt)
                              `SEPC_EXT_WRITE_DISABLE_CMD: begin
                                 wen_r <= 1'b0;
                                 st_r <= ST_DONE;
                              end
                              `SEPC_EXT_WEN: begin
                                 wen_r <= 1'b1;
                                 st_r <= ST_DONE;
                              end
                              `SEPC_EXT_ERASE_ALL_CMD: begin
                                 st_r <= ST_DONE;
                                 pend_r <= wen_r;
                                 all_r <= 1'b1;
                                 data_r <= `SEPC_ERASED;
                              end
                              default: begin
                                 st_r <= ST_CMD;
                                 all_r <= 1'b1;
                              end
                           endcase
                        end
                     endcase
                  end else if (cnt_nxt == data_end(word_r)) begin
                     // Data complete for single or all-location write
                     st_r <= ST_DONE;
                     data_r <= data_nxt;
                     pend_r <= wen_r;
                  end
               end
            end
            ST_READ: begin
               if (!cs_s) begin
                  st_r <= ST_STANDBY;
               end else if (serial_clock_in_rise) begin
                  if (rem_r == 5'h00) begin
                     // Load next word and advance the pointer
                     rd_bit_r <= rd_sel[15];
                     sh_r <= {rd_sel[14:0], 1'b0};
                     rem_r <= data_width(word_r) - 5'h01;
                     ptr_r <= ptr_inc;
                  end else begin
                     rd_bit_r <= sh_r[15];
                     sh_r <= {sh_r[14:0], 1'b0};
                     rem_r <= rem_r - 5'h01;
                  end
               end
            end
            ST_DONE: begin
               if (!cs_s) begin
                  // Falling chip select launches an accepted program
                  st_r <= pend_r ? ST_PROG : ST_STANDBY;
                  prog_cnt_r <= 18'h00000;
               end else if (serial_clock_in_rise) begin
                  // Extra clock breaks the framing: drop a pending program; an EWEN/EWDS latch change already made stands
                  st_r <= ST_IGNORE;
                  pend_r <= 1'b0;
               end
            end
            ST_PROG: begin
               // Serial clocks are ignored until the timer expires
               if (prog_cnt_r == PROG_LAST) begin
                  st_r <= ST_STANDBY;
                  pend_r <= 1'b0;
               end
               prog_cnt_r <= prog_cnt_r + 18'h00001;
            end
            ST_IGNORE: begin
               if (!cs_s) begin
                  st_r <= ST_STANDBY;
               end
            end
            default: begin
               st_r <= ST_RESET;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Data output pin
   // ------------------------------------------------------------
   // Read data while reading, busy or ready while status is open
   always @(posedge SYS_CLK) begin
      if (RESET || por_s) begin
         dout_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         oe_r <= cs_s && (st_r == ST_READ || stat_r);
         if (st_r == ST_READ) begin
            dout_r <= rd_bit_r;
         end else begin
            dout_r <= (st_r != ST_PROG);
         end
      end
   end

   assign DATA_OUT = dout_r;
   assign DATA_OUT_OE = oe_r;
   assign PROG_BUSY = (st_r == ST_PROG);
   assign WRITE_ENABLED = wen_r;

endmodule

// ==== dv/sepc_core_properties.sv ====
// Concurrent checks on the command port pins
`timescale 1ns/1ps
module sepc_core_properties #(
   parameter PROG_CYCLES = 300
) (
   // System
   input wire SYS_CLK,
   input wire RESET,
   input wire POR_ACTIVE,
   // Serial pins
   input wire CHIP_SELECT,
   input wire SERIAL_CLOCK_IN,
   input wire DATA_IN,
   input wire ORGANIZATION_SELECT,
   // Outputs
   input wire DATA_OUT,
   input wire DATA_OUT_OE,
   input wire PROG_BUSY,
   input wire WRITE_ENABLED
);
   reg [31:0] busy_cnt_r;
   // Length of the running program cycle
   always @(posedge SYS_CLK) begin
      if (RESET || !PROG_BUSY) busy_cnt_r <= 32'h0;
      else busy_cnt_r <= busy_cnt_r + 32'h1;
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_POR_QUIET: assert property (
      POR_ACTIVE [*4] |-> !DATA_OUT_OE && !PROG_BUSY && !WRITE_ENABLED)
      else $error("outputs active during supply reset");
   AST_CS_IDLE: assert property (
      (!CHIP_SELECT) [*5] |-> !DATA_OUT_OE)
      else $error("output driven with select low");
   AST_WEN_NEEDED: assert property (
      $rose(PROG_BUSY) |-> WRITE_ENABLED)
      else $error("program cycle without write enable");
   AST_BUSY_AFTER_CS_LOW: assert property (
      $rose(PROG_BUSY) |-> !CHIP_SELECT)
      else $error("program cycle began with select high");
   AST_BUSY_LENGTH: assert property (
      $fell(PROG_BUSY) |-> busy_cnt_r == PROG_CYCLES)
      else $error("program cycle length wrong");
   AST_STATUS_BUSY: assert property (
      PROG_BUSY && DATA_OUT_OE |-> !DATA_OUT)
      else $error("status not busy during program");
   AST_STATUS_READY: assert property (
      DATA_OUT_OE && $fell(PROG_BUSY) |-> ##[0:3] DATA_OUT)
      else $error("status not ready after program");
   AST_DUMMY_ZERO: assert property (
      $rose(DATA_OUT_OE) |-> !DATA_OUT)
      else $error("first output bit not zero");
   AST_WEN_NEEDS_CS: assert property (
      (!CHIP_SELECT) [*6] |-> !$rose(WRITE_ENABLED))
      else $error("write enable set with select low");
endmodule

// ==== dv/sepc_host.sv ====
// Host model driving the serial link
`timescale 1ns/1ps
module sepc_host (
   // Pins driven by the host
   output reg cs,
   output reg serial_clock_in,
   output reg din,
   // Pins from the device
   input wire dout,
   input wire dout_oe
);
   // Released data line reads as the inverse of the device's current dout level
   wire line_w = dout_oe ? dout : ~dout;
   // Idle link: clock parked low, select low
   initial begin
      cs = 1'b0;
      serial_clock_in = 1'b0;
      din = 1'b0;
   end
   // Shift a framed instruction MSB first with its exact clock count
   task send(input [31:0] bits, input integer n);
      integer i;
      begin
         cs = 1'b1;
         for (i = n - 1; i >= 0; i = i - 1) begin
            din = bits[i];
            #50 serial_clock_in = 1'b1;
            #100 serial_clock_in = 1'b0;
            #50;
         end
      end
   endtask
   // Close the frame; data line no longer meaningful
   task finish;
      begin
         cs = 1'b0;
         din = ~din;
         #250;
      end
   endtask
   // Clock n bits out of the device, sampled late in each period
   task fetch(output [31:0] v, input integer n);
      integer i;
      begin
         v = 32'h0;
         for (i = 0; i < n; i = i + 1) begin
            din = ~din;
            #50 serial_clock_in = 1'b1;
            #100 serial_clock_in = 1'b0;
            #40 v = {v[30:0], line_w};
            #10;
         end
      end
   endtask
   // Raise select and poll status until ready before any new command
   task status(output first, output last);
      integer w;
      begin
         cs = 1'b1;
         #200 first = line_w;
         w = 0;
         while (line_w !== 1'b1 && w < 2000) begin
            #25 w = w + 1;
         end
         last = line_w;
         finish;
      end
   endtask
endmodule

// ==== dv/sepc_core_tb_top.sv ====
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
module sepc_core_tb_top;
   localparam PROG_CYCLES = 300;
   reg sys_clk;
   reg reset;
   reg por_active;
   reg organization_select;
   wire cs, serial_clock_in, din, dout, dout_oe, prog_busy, write_enabled;
   integer fails;
   integer checks;
   reg [31:0] v;
   reg first;
   reg last;
   // ------------------------------------------------------------
   // Design, host and clock
   // ------------------------------------------------------------
   sepc_core #(.PROG_CYCLES(PROG_CYCLES)) sepc_core_i (
      .SYS_CLK(sys_clk), .RESET(reset), .POR_ACTIVE(por_active),
      .CHIP_SELECT(cs), .SERIAL_CLOCK_IN(serial_clock_in), .DATA_IN(din),
      .ORGANIZATION_SELECT(organization_select), .DATA_OUT(dout), .DATA_OUT_OE(dout_oe),
      .PROG_BUSY(prog_busy), .WRITE_ENABLED(write_enabled));
   sepc_host sepc_host_i (.cs(cs), .serial_clock_in(serial_clock_in), .din(din),
      .dout(dout), .dout_oe(dout_oe));
   // System clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task cmd(input [31:0] bits, input integer n);
      begin
         sepc_host_i.send(bits, n);
         sepc_host_i.finish;
      end
   endtask
   task prog_cmd(input [31:0] bits, input integer n);
      begin
         cmd(bits, n);
         check(prog_busy, 1'b1);
         sepc_host_i.status(first, last);
         check(first, 1'b0);
         check(last, 1'b1);
         check(prog_busy, 1'b0);
      end
   endtask
   task read(input [31:0] bits, input integer n, input integer m, input [31:0] exp);
      begin
         sepc_host_i.send(bits, n);
         check({dout_oe, dout}, 2'b10);
         sepc_host_i.fetch(v, m);
         check(v, exp);
         sepc_host_i.finish;
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_byte;
      begin
         cmd(32'h980, 12);
         check(write_enabled, 1'b1);
         prog_cmd(32'h8803c, 20);
         prog_cmd(32'hbffa5, 20);
         read(32'hdff, 12, 16, 32'ha53c);
         prog_cmd(32'he00, 12);
         read(32'hc00, 12, 16, 32'hff3c);
         cmd(32'h800, 12);
         check(write_enabled, 1'b0);
         cmd(32'hbff00, 20);
         #500 check(prog_busy, 1'b0);
         read(32'hdff, 12, 8, 32'ha5);
      end
   endtask
   task t_word;
      begin
         @(posedge sys_clk);
         #2 organization_select = 1'b1;
         cmd(32'h4c0, 11);
         check(write_enabled, 1'b1);
         prog_cmd(32'h5101234, 27);
         read(32'h610, 11, 16, 32'h1234);
         prog_cmd(32'h480, 11);
         read(32'h610, 11, 16, 32'hffff);
         // A write framed with one clock too many must be dropped
         cmd(32'ha20aaaa, 28);
         #500 check(prog_busy, 1'b0);
         read(32'h610, 11, 16, 32'hffff);
      end
   endtask
   task t_por;
      begin
         cmd(32'h400, 11);
         check(write_enabled, 1'b0);
         cmd(32'h4c0, 11);
         check(write_enabled, 1'b1);
         // Supply reset clears the latch and ignores instructions
         @(posedge sys_clk);
         #2 por_active = 1'b1;
         repeat (8) @(posedge sys_clk);
         #2 check(write_enabled, 1'b0);
         cmd(32'h4c0, 11);
         check(write_enabled, 1'b0);
         @(posedge sys_clk);
         #2 por_active = 1'b0;
         repeat (8) @(posedge sys_clk);
         // Brown-out in mid-instruction with the latch set
         #2 cmd(32'h4c0, 11);
         sepc_host_i.send(32'h26, 6);
         @(posedge sys_clk);
         #2 por_active = 1'b1;
         repeat (8) @(posedge sys_clk);
         #2 sepc_host_i.finish;
         @(posedge sys_clk);
         #2 por_active = 1'b0;
         repeat (8) @(posedge sys_clk);
         #2 check(write_enabled, 1'b0);
         check(prog_busy, 1'b0);
         cmd(32'h4c0, 11);
         check(write_enabled, 1'b1);
      end
   endtask
   // Main sequence
   initial begin
      fails = 0;
      checks = 0;
      reset = 1'b1;
      por_active = 1'b0;
      organization_select = 1'b0;
      repeat (16) @(posedge sys_clk);
      #2 reset = 1'b0;
      repeat (8) @(posedge sys_clk);
      #2;
      t_byte;
      t_word;
      t_por;
      report_and_stop;
   end
   // Watchdog against a hung handshake
   initial begin
      #1000000;
      fails = fails + 1;
      report_and_stop;
   end
endmodule
bind sepc_core sepc_core_properties #(.PROG_CYCLES(PROG_CYCLES)) sepc_core_properties_i (
   .SYS_CLK(SYS_CLK), .RESET(RESET), .POR_ACTIVE(POR_ACTIVE), .CHIP_SELECT(CHIP_SELECT),
   .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .DATA_IN(DATA_IN),
   .ORGANIZATION_SELECT(ORGANIZATION_SELECT), .DATA_OUT(DATA_OUT),
   .DATA_OUT_OE(DATA_OUT_OE), .PROG_BUSY(PROG_BUSY), .WRITE_ENABLED(WRITE_ENABLED));
